// *** rtl/udmc_pkg.sv ***
/*
 * udmc_pkg: constants, register map and types for the up/down modulo counter.
 * assumes: used by the counter core, the apb slave and the top module.
 */
`default_nettype none
package udmc_pkg;
	// count width: integer bits plus fraction bits
	localparam int INT_BITS = 16;
	localparam int FRAC_BITS = 0;
	localparam int CNT_W = INT_BITS + FRAC_BITS;
	localparam int MOD_MAX_W = 31;
	localparam bit MOD_ALLOWED = (CNT_W <= MOD_MAX_W);
	localparam bit SET_ALLOWED = (CNT_W <= MOD_MAX_W);

	// bus number formats
	typedef enum logic [1:0] {
		UDMC_FMT_SINT = 2'h0,
		UDMC_FMT_UINT = 2'h1,
		UDMC_FMT_SFRAC = 2'h2
	} udmc_fmt_e;

	// counting direction choices
	typedef enum logic [1:0] {
		UDMC_DIR_INC = 2'h0,
		UDMC_DIR_DEC = 2'h1,
		UDMC_DIR_PORT = 2'h2
	} udmc_dir_e;

	// apb register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_MODULUS = 12'h004;
	localparam logic [11:0] ADDR_PRESET = 12'h008;
	localparam logic [11:0] ADDR_DATA = 12'h00c;
	localparam logic [11:0] ADDR_STROBE = 12'h010;
	localparam logic [11:0] ADDR_COUNT = 12'h014;

	// control register fields
	localparam int CTRL_CLK_ENA = 0;
	localparam int CTRL_CNT_ENA = 1;
	localparam int CTRL_UP = 2;
	localparam int CTRL_MOD_EN = 3;
	localparam int CTRL_DIR_LO = 4;
	localparam int CTRL_FMT_LO = 6;
	localparam int CTRL_W = 8;

	// strobe register fields (write one to pulse)
	localparam int STB_CLEAR = 0;
	localparam int STB_SET = 1;
	localparam int STB_LOAD = 2;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h07;
	localparam logic [CNT_W-1:0] MODULUS_RESET = 16'h000a;
	localparam logic [CNT_W-1:0] PRESET_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// *** rtl/udmc_core.sv ***
/*
 * udmc_core: counting datapath with clear, set, load, gating and modulus.
 * assumes: controls synchronous to pclk; modulus and preset held stable by software.
 */
`default_nettype none
module udmc_core
	import udmc_pkg::*;
(
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic clk_ena, // freezes everything when low
	input wire logic cnt_ena, // stops counting only when low
	input wire logic up, // direction pin, 1 counts up
	input wire udmc_dir_e dir_mode, // fixed or pin-selected direction
	input wire logic mod_en, // modulo operation on
	input wire logic [CNT_W-1:0] modulus, // number of distinct states
	input wire logic [CNT_W-1:0] preset, // value taken on set
	input wire logic [CNT_W-1:0] load_data, // parallel data
	input wire logic clear, // synchronous clear strobe
	input wire logic set, // synchronous set strobe
	input wire logic load, // synchronous load strobe
	output logic [CNT_W-1:0] count // registered count
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} udmc_core_s;
	udmc_core_s state_reg, state_next;
	logic count_up;
	logic use_mod;
	logic [CNT_W-1:0] top;

	// one lsb of any format is bit 0, so plain +/-1 serves all three formats
	always_comb begin
		unique case (dir_mode)
			UDMC_DIR_INC: count_up = 1'b1;
			UDMC_DIR_DEC: count_up = 1'b0;
			UDMC_DIR_PORT: count_up = up;
			default: count_up = 1'b1;
		endcase
		use_mod = mod_en && MOD_ALLOWED && (modulus != CNT_ZERO);
		top = modulus - CNT_ONE;
		state_next = state_reg;
		if (clk_ena) begin
			if (clear) begin
				state_next.cnt = CNT_ZERO;
			end else if (set && SET_ALLOWED) begin
				state_next.cnt = preset;
			end else if (load) begin
				state_next.cnt = load_data;
			end else if (cnt_ena) begin
				if (count_up) begin
					if (use_mod && state_reg.cnt >= top)
						state_next.cnt = CNT_ZERO;
					else
						state_next.cnt = state_reg.cnt + CNT_ONE;
				end else begin
					if (use_mod && state_reg.cnt == CNT_ZERO)
						state_next.cnt = top;
					else if (use_mod && state_reg.cnt > top)
						state_next.cnt = top; // out-of-range load recovers
					else
						state_next.cnt = state_reg.cnt - CNT_ONE;
				end
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign count = state_reg.cnt;
endmodule
`default_nettype wire

// *** rtl/udmc_apb.sv ***
/*
 * udmc_apb: apb slave holding the counter controls and reading back the count.
 * assumes: the top registers the answer and passes pwrite only on its answering cycle.
 */
`default_nettype none
module udmc_apb
	import udmc_pkg::*;
(
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // write direction
	input wire logic [11:0] paddr, // byte address
	input wire logic [31:0] pwdata, // write data
	input wire logic [CNT_W-1:0] count, // live count
	output logic [31:0] prdata, // read data
	output logic pslverr, // unmapped access
	output logic [CTRL_W-1:0] ctrl, // control bits
	output logic [CNT_W-1:0] modulus, // modulus value
	output logic [CNT_W-1:0] preset, // set value
	output logic [CNT_W-1:0] load_data, // parallel data
	output logic clear, // one-cycle clear pulse
	output logic set, // one-cycle set pulse
	output logic load // one-cycle load pulse
);
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [CNT_W-1:0] modulus;
		logic [CNT_W-1:0] preset;
		logic [CNT_W-1:0] data;
		logic [2:0] stb;
	} udmc_regs_s;
	udmc_regs_s regs_reg, regs_next;
	logic wr;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == ADDR_CTRL) || (a == ADDR_MODULUS) || (a == ADDR_PRESET) ||
			(a == ADDR_DATA) || (a == ADDR_STROBE) || (a == ADDR_COUNT);
	endfunction

	// writes land at the access phase; strobes live for one cycle only
	always_comb begin
		wr = psel && penable && pwrite;
		regs_next = regs_reg;
		regs_next.stb = 3'h0;
		if (wr) begin
			unique case (paddr)
				ADDR_CTRL: regs_next.ctrl = pwdata[CTRL_W-1:0];
				ADDR_MODULUS: regs_next.modulus = pwdata[CNT_W-1:0];
				ADDR_PRESET: regs_next.preset = pwdata[CNT_W-1:0];
				ADDR_DATA: regs_next.data = pwdata[CNT_W-1:0];
				ADDR_STROBE: regs_next.stb = pwdata[2:0];
				default: regs_next.stb = 3'h0;
			endcase
		end
	end

	// register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs_reg.ctrl <= CTRL_RESET;
			regs_reg.modulus <= MODULUS_RESET;
			regs_reg.preset <= PRESET_RESET;
			regs_reg.data <= CNT_ZERO;
			regs_reg.stb <= 3'h0;
		end else begin
			regs_reg <= regs_next;
		end
	end

	// read mux; the top registers it and raises pready one cycle into the access
	always_comb begin
		prdata = RDATA_ZERO;
		pslverr = psel && penable && !mapped(paddr);
		unique case (paddr)
			ADDR_CTRL: prdata[CTRL_W-1:0] = regs_reg.ctrl;
			ADDR_MODULUS: prdata[CNT_W-1:0] = regs_reg.modulus;
			ADDR_PRESET: prdata[CNT_W-1:0] = regs_reg.preset;
			ADDR_DATA: prdata[CNT_W-1:0] = regs_reg.data;
			ADDR_COUNT: prdata[CNT_W-1:0] = count;
			default: prdata = RDATA_ZERO;
		endcase
	end

	assign ctrl = regs_reg.ctrl;
	assign modulus = regs_reg.modulus;
	assign preset = regs_reg.preset;
	assign load_data = regs_reg.data;
	assign clear = regs_reg.stb[STB_CLEAR];
	assign set = regs_reg.stb[STB_SET];
	assign load = regs_reg.stb[STB_LOAD];
endmodule
`default_nettype wire

// *** rtl/udmc_top.sv ***
/*
 * udmc_top: up/down modulo counter with apb control and direct pin strobes.
 * assumes: one clock pclk at 125 MHz; pins synchronous to pclk.
 */
// The register addresses and register access over APB were chosen for this implementation.
`default_nettype none
module udmc_top
	import udmc_pkg::*;
(
	input wire logic pclk, // 125 MHz clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb write
	input wire logic [11:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic clk_ena_pin, // clock enable pin, and-ed with control
	input wire logic cnt_ena_pin, // count enable pin, and-ed with control
	input wire logic up_pin, // direction pin
	input wire logic clear_pin, // clear strobe pin
	input wire logic set_pin, // set strobe pin
	input wire logic load_pin, // load strobe pin
	input wire logic [udmc_pkg::CNT_W-1:0] data_pin, // parallel data pin
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	output logic [udmc_pkg::CNT_W-1:0] count, // registered count
	output logic count_sign // msb of a signed count
);
	logic [CTRL_W-1:0] ctrl;
	logic [CNT_W-1:0] modulus, preset, reg_data, load_val, cnt;
	logic rclear, rset, rload;
	udmc_fmt_e fmt;
	udmc_dir_e dir_mode;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} udmc_top_s;
	udmc_top_s bus_reg, bus_next;
	logic [31:0] rdata_mux;
	logic slverr_mux;
	logic first_access;

	udmc_apb u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite & bus_reg.pready), // a write lands only on the answering edge
		.paddr(paddr),
		.pwdata(pwdata),
		.count(cnt),
		.prdata(rdata_mux),
		.pslverr(slverr_mux),
		.ctrl(ctrl),
		.modulus(modulus),
		.preset(preset),
		.load_data(reg_data),
		.clear(rclear),
		.set(rset),
		.load(rload)
	);

	// pin load wins over the software data word when both strobe together;
	// one wait state buys registered read data, error and ready at the pins
	always_comb begin
		fmt = udmc_fmt_e'(ctrl[CTRL_FMT_LO +: 2]);
		dir_mode = udmc_dir_e'(ctrl[CTRL_DIR_LO +: 2]);
		load_val = load_pin ? data_pin : reg_data;
		first_access = psel & penable & ~bus_reg.pready;
		bus_next = bus_reg;
		bus_next.pready = first_access;
		bus_next.pslverr = first_access & slverr_mux;
		if (first_access)
			bus_next.prdata = rdata_mux; // held until the next access
	end

	udmc_core u_core (
		.pclk(pclk),
		.presetn(presetn),
		.clk_ena(ctrl[CTRL_CLK_ENA] & clk_ena_pin),
		.cnt_ena(ctrl[CTRL_CNT_ENA] & cnt_ena_pin),
		.up(ctrl[CTRL_UP] ? up_pin : 1'b0),
		.dir_mode(dir_mode),
		.mod_en(ctrl[CTRL_MOD_EN]),
		.modulus(modulus),
		.preset(preset),
		.load_data(load_val),
		.clear(clear_pin | rclear),
		.set(set_pin | rset),
		.load(load_pin | rload),
		.count(cnt)
	);

	// count and sign go out straight from the core register; the sign bit
	// is meaningful only for signed formats unsigned reads zero
	assign count = cnt;
	assign count_sign = (fmt != UDMC_FMT_UINT) & cnt[CNT_W-1];

	// bus answer register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bus_reg <= '0;
		else
			bus_reg <= bus_next;
	end

	assign prdata = bus_reg.prdata;
	assign pready = bus_reg.pready;
	assign pslverr = bus_reg.pslverr;
endmodule
`default_nettype wire

// *** test/udmc_sva.sv ***
/* udmc_sva: port assertions for the counter top.
 assumes the control enable bit stays set and pin strobes never meet register strobes. */
`default_nettype none
module udmc_sva
	import udmc_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pready, // apb ready
	input wire logic clk_ena_pin, // freeze gate
	input wire logic cnt_ena_pin, // count gate
	input wire logic clear_pin, // clear
	input wire logic set_pin, // set
	input wire logic load_pin, // load
	input wire logic [udmc_pkg::CNT_W-1:0] data_pin, // data
	input wire logic [udmc_pkg::CNT_W-1:0] count, // count
	input wire logic count_sign // sign
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic psel_q;
	logic calm;
	// a register write strobes the counter the cycle after psel, so that cycle is left out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) psel_q <= 1'b0;
		else psel_q <= psel;
	end
	assign calm = clk_ena_pin && !clear_pin && !set_pin && !load_pin && !psel_q;
	sequence s_load;
		clk_ena_pin && load_pin && !clear_pin && !set_pin;
	endsequence
	sequence s_hold;
		calm && !cnt_ena_pin;
	endsequence
	AST_FREEZE: assert property (!clk_ena_pin |=> $stable(count))
		else $error("count moved while frozen");
	AST_CLEAR: assert property (clk_ena_pin && clear_pin |=> count == CNT_ZERO)
		else $error("clear missed");
	AST_PRIO: assert property (clk_ena_pin && clear_pin && set_pin && load_pin |=> count == 0)
		else $error("clear lost priority");
	AST_LOAD: assert property (s_load |=> count == $past(data_pin))
		else $error("load missed");
	AST_HOLD: assert property (s_load ##1 s_hold |=> count == $past(data_pin, 2))
		else $error("loaded value not held");
	AST_GATE: assert property (s_hold |=> $stable(count))
		else $error("counted while gated");
	AST_STEP: assert property (calm && cnt_ena_pin |=> (count == $past(count) + CNT_ONE) ||
		(count == $past(count) - CNT_ONE) || (count == $past(count)) ||
		(count == CNT_ZERO) || ($past(count) == CNT_ZERO)) else $error("step not one lsb");
	AST_SIGN: assert property (count_sign |-> count[CNT_W-1])
		else $error("sign without msb");
	AST_ANSWER: assert property (psel && penable && !pready |=> pready)
		else $error("bus access not answered");
endmodule
bind udmc_top udmc_sva u_sva (.pclk, .presetn, .psel, .penable, .pready, .clk_ena_pin, .cnt_ena_pin,
	.clear_pin, .set_pin, .load_pin, .data_pin, .count, .count_sign);
`default_nettype wire

// *** test/udmc_ctl.sv ***
/* udmc_ctl: surrounding logic that drives the counter pins.
 assumes drive is called just after a rising pclk edge. */
`default_nettype none
module udmc_ctl
	import udmc_pkg::*;
(
	output var logic clk_ena_pin, // freeze gate
	output var logic cnt_ena_pin, // count gate
	output var logic up_pin, // high counts up
	output var logic clear_pin, // clear
	output var logic set_pin, // set
	output var logic load_pin, // load
	output var logic [udmc_pkg::CNT_W-1:0] data_pin // data
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle: running, not counting, no strobes
	initial begin
		{clk_ena_pin, cnt_ena_pin, up_pin, clear_pin, set_pin, load_pin} = 6'h20;
		data_pin = 16'h0000;
	end
	// levels change only after an edge, so the counter samples them at the next one
	task automatic drive(input logic [5:0] v, input logic [CNT_W-1:0] d);
		{clk_ena_pin, cnt_ena_pin, up_pin, clear_pin, set_pin, load_pin} <= v;
		data_pin <= d;
	endtask
endmodule
`default_nettype wire

// *** test/test_updown_modulo_counter.sv ***
/* test_updown_modulo_counter: directed scenarios over apb and pins.
 assumes udmc_ctl drives the pins and the checker is bound to the top. */
`default_nettype none
module test_updown_modulo_counter import udmc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, count_sign, err, clk_ena_pin, cnt_ena_pin, up_pin;
	logic clear_pin, set_pin, load_pin;
	logic [CNT_W-1:0] data_pin, count;
	int mismatches = 0;
	int n_tests = 0;
	always #4 pclk = ~pclk;
	udmc_ctl ctl (.clk_ena_pin, .cnt_ena_pin, .up_pin, .clear_pin, .set_pin, .load_pin, .data_pin);
	udmc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .clk_ena_pin,
		.cnt_ena_pin, .up_pin, .clear_pin, .set_pin, .load_pin, .data_pin, .prdata, .pready,
		.pslverr, .count, .count_sign);
	task automatic close_out();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; an idle edge follows so psel is never re-driven in one step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// count is read mid-cycle, after the edge's updates have landed
	task automatic chk_cnt(input logic [CNT_W-1:0] e);
		@(negedge pclk);
		check("count", {16'h0, e}, {16'h0, count});
		@(posedge pclk);
	endtask
	task automatic pulse(input logic [5:0] v, input logic [CNT_W-1:0] d, input logic [CNT_W-1:0] e);
		ctl.drive(v, d);
		repeat (v[4] ? 1 : 1) @(posedge pclk);
		ctl.drive(6'h20, d);
		chk_cnt(e);
	endtask
	task automatic run(input logic up, input int n, input logic [CNT_W-1:0] e);
		ctl.drive({2'b11, up, 3'b000}, 16'h0000);
		repeat (n) @(posedge pclk);
		ctl.drive(6'h20, 16'h0);
		chk_cnt(e);
	endtask
	task automatic t_reset();
		logic [11:0] a[6] = '{ADDR_CTRL, ADDR_MODULUS, ADDR_PRESET, ADDR_STROBE, ADDR_COUNT, 12'h018};
		logic [31:0] e[6] = '{32'h7, 32'ha, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, a[i], 32'h0);
			check("reset read", e[i], rd);
			check("slave error", {31'h0, i == 5}, {31'h0, err});
		end
	endtask
	task automatic t_modulo();
		apb(1'b1, ADDR_CTRL, 32'h2f);
		run(1'b1, 12, 16'h0002);
		run(1'b0, 3, 16'h0009);
	endtask
	task automatic t_dirs();
		for (int d = 0; d < 2; d++) begin
			apb(1'b1, ADDR_CTRL, 32'h07 | (d << 4));
			pulse(6'b100100, 16'h0, 16'h0000);
			run(d[0], 3, d ? 16'hfffd : 16'h0003);
			check("sign", {31'h0, d[0]}, {31'h0, count_sign});
		end
		apb(1'b1, ADDR_CTRL, 32'h57);
		check("unsigned sign", 32'h0, {31'h0, count_sign});
	endtask
	task automatic t_prio();
		apb(1'b1, ADDR_PRESET, 32'h5);
		pulse(6'b111111, 16'h1234, 16'h0000);
		pulse(6'b110011, 16'h1234, 16'h0005);
		pulse(6'b110001, 16'h1234, 16'h1234);
		pulse(6'b010111, 16'h0777, 16'h1234);
	endtask
	task automatic t_regs();
		apb(1'b1, ADDR_CTRL, 32'h05);
		apb(1'b1, ADDR_DATA, 32'hbeef);
		apb(1'b1, ADDR_STROBE, 32'h4);
		run(1'b1, 3, 16'hbeef);
		apb(1'b1, ADDR_STROBE, 32'h2);
		apb(1'b0, ADDR_COUNT, 32'h0);
		check("count read", 32'h5, rd);
	endtask
	initial begin
		#20us;
		mismatches++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_modulo();
		t_dirs();
		t_prio();
		t_regs();
		close_out();
	end
endmodule
`default_nettype wire
